// ---- src/clk_ctrl_pkg.sv ----
// Purpose: Constants for the system clock divider and oscillator control block
// Assumes: 8-bit CPU-side register port, 16-bit address, one clock mclk
// Notes:   Register addresses are the CPU data-space addresses
//
// Overview of operation
// [RL1] Slow 240 kHz oscillator runs; software may halt it only if option allows
// [RL2] Reset loads CPU divider and prescaler registers with 02H
// [RL3] CPU clock ratio from prescale bits and CPU divide bit; other codes prohibited
// [RL4] Peripheral clock is system clock /2 at 01H, /4 at 02H
// [RL5] Minimum instruction time equals two CPU clock periods
// [RL6] If stopping forbidden, ignore mode register, keep running, watchdog source fixed
// [RL7] Reset clears slow oscillator mode register to 00H
// [RL8] Mode bit 0: zero runs, one halts slow oscillator when allowed
// [RL9] Settle wait after STOP applies only with crystal or ceramic source
// [RL10] Settle select 00/01/10/11 gives 2^10, 2^12, 2^15, 2^17 cycles
// [RL11] Software writes settle select register with whole-byte accesses only
// [RL12] Bit and byte writes accepted for divider, prescaler and mode registers
// [RL13] Settle select register is not initialised by reset
// [RL14] Settle count starts only once oscillation has begun
// [RL15] Software programs settle time at least the resonator's expected time
// [RL16] Source and power-up wait come from option byte, not settle select
// [RL17] Option byte selects internal 8 MHz, crystal/ceramic or external clock
// [RL18] Ratio changes take effect on divided-clock boundary, no runt pulses

package clk_ctrl_pkg;

  localparam logic [15:0] ADDR_SLOW_OSC_MODE   = 16'hFF58;
  localparam logic [15:0] ADDR_PRESCALER_CTRL  = 16'hFFF3;
  localparam logic [15:0] ADDR_WAKE_SETTLE_SEL = 16'hFFF4;
  localparam logic [15:0] ADDR_CPU_DIVIDER     = 16'hFFFB;

  localparam logic [7:0] RST_SLOW_OSC_MODE  = 8'h00;
  localparam logic [7:0] RST_PRESCALER_CTRL = 8'h02;
  localparam logic [7:0] RST_CPU_DIVIDER    = 8'h02;

  localparam int CPU_DIV_BIT_POS     = 1;
  localparam int PRESCALE_LO_POS     = 0;
  localparam int PRESCALE_HI_POS     = 1;
  localparam int SLOW_OSC_HALT_POS   = 0;
  localparam int SETTLE_SEL_LO_POS   = 0;
  localparam int SETTLE_SEL_HI_POS   = 1;

  localparam logic [7:0] CPU_DIVIDER_MASK  = 8'h02;
  localparam logic [7:0] PRESCALER_MASK    = 8'h03;
  localparam logic [7:0] SLOW_OSC_MASK     = 8'h01;
  localparam logic [7:0] SETTLE_SEL_MASK   = 8'h03;

  // Settle exponents for select codes 00, 01, 10, 11
  localparam int SETTLE_EXP_0 = 10;
  localparam int SETTLE_EXP_1 = 12;
  localparam int SETTLE_EXP_2 = 15;
  localparam int SETTLE_EXP_3 = 17;
  localparam int SETTLE_CNT_W = 18;

  // Division exponents of system clock
  localparam logic [2:0] DIV_EXP_PRESC_01 = 3'h1;
  localparam logic [2:0] DIV_EXP_PRESC_10 = 3'h2;
  localparam int DIV_CNT_W = 4;

  // Option byte clock source encoding
  typedef enum logic [1:0] {
    SRC_INT_HS  = 2'h0,
    SRC_XTAL    = 2'h1,
    SRC_EXT_CLK = 2'h2
  } clk_src_e;

  // Nominal oscillator and instruction timing figures, for reference by users of this block
  localparam int SLOW_OSC_KHZ = 240;
  localparam int INT_HS_KHZ   = 8000;
  localparam int MIN_INSTR_CPU_CLKS = 2;

endpackage

// ---- src/clk_pulse_div.sv ----
// Purpose: Glitch-free power-of-two enable divider
// Assumes: Ratio exponent sampled only at the end of a divided period
// Notes:   Produces a one-cycle enable per divided period

`timescale 1ns/1ps

module clk_pulse_div #(
  parameter int EXP_W = 3,
  parameter int CNT_W = 4
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic             run,
  input  wire logic [EXP_W-1:0] exp_req,
  output logic                  tick,
  output logic [EXP_W-1:0]      exp_cur
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [EXP_W-1:0] exp_r;
  logic [EXP_W-1:0] exp_nxt;
  logic             tick_r;
  logic             tick_nxt;
  logic [CNT_W-1:0] last;

  always_comb
  begin
    last     = CNT_W'((1 << exp_r) - 1);
    cnt_nxt  = cnt_r;
    exp_nxt  = exp_r;
    tick_nxt = 1'b0;
    if (run)
    begin
      if (cnt_r >= last)
      begin
        // New ratio only at a period boundary so no short period escapes
        cnt_nxt  = '0; // RL18
        exp_nxt  = exp_req; // RL18
        tick_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      cnt_r  <= '0;
      exp_r  <= '0;
      tick_r <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_r  <= cnt_nxt;
      exp_r  <= exp_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick    = tick_r;
  assign exp_cur = exp_r;

endmodule

// ---- src/clk_ctrl.sv ----
// Purpose: System clock divider, slow oscillator control, wake settle timer
// Assumes: CPU register port is one 8-bit access per cycle, bit writes as mask
// Notes:   Divided clocks are delivered as one-cycle enables on mclk

`timescale 1ns/1ps

module clk_ctrl (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_bit_wr,
  input  wire logic [7:0]  reg_wmask,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  input  wire logic [1:0]  opt_clk_src,
  input  wire logic        opt_slow_stoppable,
  input  wire logic        stop_release,
  input  wire logic        osc_started,
  output logic             slow_osc_run,
  output logic             watchdog_src_fixed,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic [2:0]       cpu_div_exp,
  output logic             div_setting_bad,
  output logic             settle_busy,
  output logic             settle_done
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] cpu_div_r;
  logic [7:0] cpu_div_nxt;
  logic [7:0] presc_r;
  logic [7:0] presc_nxt;
  logic [7:0] slow_mode_r;
  logic [7:0] slow_mode_nxt;
  logic [7:0] settle_sel_r;
  logic [7:0] settle_sel_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] wr_val;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
                                       input logic [7:0] msk, input logic bitw);
    merge = bitw ? ((old & ~msk) | (val & msk)) : val;
  endfunction

  always_comb
  begin
    wr_val         = reg_wdata;
    cpu_div_nxt    = cpu_div_r;
    presc_nxt      = presc_r;
    slow_mode_nxt  = slow_mode_r;
    settle_sel_nxt = settle_sel_r;
    rdata_nxt      = rdata_r;
    if (reg_wr)
    begin
      unique case (reg_addr)
        clk_ctrl_pkg::ADDR_CPU_DIVIDER:
          cpu_div_nxt = merge(cpu_div_r, wr_val, reg_wmask, reg_bit_wr)
                        & clk_ctrl_pkg::CPU_DIVIDER_MASK; // RL12
        clk_ctrl_pkg::ADDR_PRESCALER_CTRL:
          presc_nxt = merge(presc_r, wr_val, reg_wmask, reg_bit_wr)
                      & clk_ctrl_pkg::PRESCALER_MASK; // RL12
        clk_ctrl_pkg::ADDR_SLOW_OSC_MODE:
          slow_mode_nxt = merge(slow_mode_r, wr_val, reg_wmask, reg_bit_wr)
                          & clk_ctrl_pkg::SLOW_OSC_MASK; // RL12
        // Bit writes here are a software fault; the whole byte is taken regardless
        clk_ctrl_pkg::ADDR_WAKE_SETTLE_SEL:
          settle_sel_nxt = wr_val & clk_ctrl_pkg::SETTLE_SEL_MASK; // RL11
        default:
          settle_sel_nxt = settle_sel_r;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        clk_ctrl_pkg::ADDR_CPU_DIVIDER:     rdata_nxt = cpu_div_r;
        clk_ctrl_pkg::ADDR_PRESCALER_CTRL:  rdata_nxt = presc_r;
        clk_ctrl_pkg::ADDR_SLOW_OSC_MODE:   rdata_nxt = slow_mode_r;
        clk_ctrl_pkg::ADDR_WAKE_SETTLE_SEL: rdata_nxt = settle_sel_r;
        default:                            rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      cpu_div_r   <= clk_ctrl_pkg::RST_CPU_DIVIDER; // RL2
      presc_r     <= clk_ctrl_pkg::RST_PRESCALER_CTRL; // RL2
      slow_mode_r <= clk_ctrl_pkg::RST_SLOW_OSC_MODE; // RL7
      rdata_r     <= 8'h00;
    end
    else if (clk_en)
    begin
      cpu_div_r   <= cpu_div_nxt;
      presc_r     <= presc_nxt;
      slow_mode_r <= slow_mode_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // Left out of reset on purpose; reads back whatever power-up leaves
  always_ff @(posedge mclk)
  begin
    if (clk_en)
    begin
      settle_sel_r <= settle_sel_nxt; // RL13
    end
  end

  assign reg_rdata = rdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // Slow oscillator control

  assign slow_osc_run = !(opt_slow_stoppable
                          && slow_mode_r[clk_ctrl_pkg::SLOW_OSC_HALT_POS]); // RL1 RL6 RL8
  assign watchdog_src_fixed = !opt_slow_stoppable; // RL6

  //////////////////////////////////////////////////////////////////////////////
  // Divider selection

  logic [2:0] code;
  logic [2:0] presc_exp;
  logic [2:0] cpu_exp;

  assign code = {presc_r[clk_ctrl_pkg::PRESCALE_HI_POS],
                 presc_r[clk_ctrl_pkg::PRESCALE_LO_POS],
                 cpu_div_r[clk_ctrl_pkg::CPU_DIV_BIT_POS]};

  always_comb
  begin
    presc_exp       = 3'h0;
    cpu_exp         = 3'h0;
    div_setting_bad = 1'b0;
    unique case (code)
      3'h0: cpu_exp = 3'h0; // RL3
      3'h2: cpu_exp = 3'h1; // RL3
      3'h1: cpu_exp = 3'h2; // RL3
      3'h4: cpu_exp = 3'h2; // RL3
      3'h3: cpu_exp = 3'h3; // RL3
      3'h5: cpu_exp = 3'h4; // RL3
      // Prohibited codes hold the slowest ratio as a safe fallback
      default:
      begin
        cpu_exp         = 3'h4;
        div_setting_bad = 1'b1; // RL3
      end
    endcase
    unique case (presc_r[1:0])
      2'h1:    presc_exp = clk_ctrl_pkg::DIV_EXP_PRESC_01; // RL4
      2'h2:    presc_exp = clk_ctrl_pkg::DIV_EXP_PRESC_10; // RL4
      default: presc_exp = 3'h0;
    endcase
  end

  // Instruction timing in the core uses two of these enables minimum
  clk_pulse_div #(
    .EXP_W (3),
    .CNT_W (clk_ctrl_pkg::DIV_CNT_W)
  ) u_cpu_div (
    .mclk    (mclk),
    .reset   (reset),
    .clk_en  (clk_en),
    .run     (!settle_busy),
    .exp_req (cpu_exp),
    .tick    (cpu_clk_en), // RL5 RL18
    .exp_cur (cpu_div_exp)
  );

  clk_pulse_div #(
    .EXP_W (3),
    .CNT_W (clk_ctrl_pkg::DIV_CNT_W)
  ) u_periph_div (
    .mclk    (mclk),
    .reset   (reset),
    .clk_en  (clk_en),
    .run     (!settle_busy),
    .exp_req (presc_exp),
    .tick    (periph_clk_en), // RL4 RL18
    .exp_cur ()
  );

  //////////////////////////////////////////////////////////////////////////////
  // Wake settle timer after STOP release

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_START = 3'b010,
    ST_COUNT = 3'b100
  } settle_e;

  settle_e                              st_r;
  settle_e                              st_nxt;
  logic [clk_ctrl_pkg::SETTLE_CNT_W-1:0] cnt_r;
  logic [clk_ctrl_pkg::SETTLE_CNT_W-1:0] cnt_nxt;
  logic [clk_ctrl_pkg::SETTLE_CNT_W-1:0] target;
  logic                                 done_r;
  logic                                 done_nxt;
  logic [clk_ctrl_pkg::SETTLE_CNT_W-1:0] tgt_r;
  logic [clk_ctrl_pkg::SETTLE_CNT_W-1:0] tgt_nxt;

  always_comb
  begin
    unique case (settle_sel_r[1:0]) // RL10
      2'h0:    target = clk_ctrl_pkg::SETTLE_CNT_W'(1 << clk_ctrl_pkg::SETTLE_EXP_0);
      2'h1:    target = clk_ctrl_pkg::SETTLE_CNT_W'(1 << clk_ctrl_pkg::SETTLE_EXP_1);
      2'h2:    target = clk_ctrl_pkg::SETTLE_CNT_W'(1 << clk_ctrl_pkg::SETTLE_EXP_2);
      default: target = clk_ctrl_pkg::SETTLE_CNT_W'(1 << clk_ctrl_pkg::SETTLE_EXP_3);
    endcase
  end

  always_comb
  begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    tgt_nxt  = tgt_r;
    unique case (st_r)
      ST_IDLE:
        // Power-up wait is the option byte's business, so reset never arms this
        if (stop_release) // RL16
        begin
          if (opt_clk_src == clk_ctrl_pkg::SRC_XTAL) // RL9 RL17
          begin
            st_nxt  = ST_START;
            // Latched so a select write during the wait cannot cut it short
            tgt_nxt = target; // RL10
          end
          else
          begin
            done_nxt = 1'b1; // RL9
          end
        end
      ST_START:
        if (osc_started) // RL14
        begin
          st_nxt  = ST_COUNT;
          cnt_nxt = clk_ctrl_pkg::SETTLE_CNT_W'(1);
        end
      ST_COUNT:
        if (cnt_r >= tgt_r) // RL10
        begin
          st_nxt   = ST_IDLE;
          cnt_nxt  = '0;
          done_nxt = 1'b1;
        end
        else
        begin
          cnt_nxt = cnt_r + clk_ctrl_pkg::SETTLE_CNT_W'(1);
        end
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      st_r   <= ST_IDLE;
      cnt_r  <= '0;
      done_r <= 1'b0;
      tgt_r  <= '0;
    end
    else if (clk_en)
    begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
      tgt_r  <= tgt_nxt;
    end
  end

  assign settle_busy = (st_r != ST_IDLE);
  assign settle_done = done_r;

endmodule

// ---- verification/clk_ctrl_monitor.sv ----
// Purpose: Port-level assertions for the clock control block
// Assumes: clk_en dropped only briefly, with no settle wait under way
// Notes:   Bound to every clk_ctrl instance
`timescale 1ns/1ps
module clk_ctrl_monitor (
  input logic        mclk,
  input logic        reset,
  input logic        reg_rd,
  input logic [7:0]  reg_rdata,
  input logic [1:0]  opt_clk_src,
  input logic        opt_slow_stoppable,
  input logic        stop_release,
  input logic        osc_started,
  input logic        slow_osc_run,
  input logic        watchdog_src_fixed,
  input logic        cpu_clk_en,
  input logic        periph_clk_en,
  input logic [2:0]  cpu_div_exp,
  input logic        div_setting_bad,
  input logic        settle_busy,
  input logic        settle_done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  property p_wd_fixed; watchdog_src_fixed == !opt_slow_stoppable; endproperty
  a_wd_fixed: assert property (p_wd_fixed) else $error("watchdog source flag wrong");
  property p_keep_run; !opt_slow_stoppable |-> slow_osc_run; endproperty
  a_keep_run: assert property (p_keep_run) else $error("slow osc stopped");
  // One cycle of slack: the tick and busy flops update on the same edge
  property p_no_tick; settle_busy && $past(settle_busy) |-> !cpu_clk_en && !periph_clk_en;
  endproperty
  a_no_tick: assert property (p_no_tick) else $error("tick while settling");
  property p_fast_wake;
    stop_release && !settle_busy && opt_clk_src != clk_ctrl_pkg::SRC_XTAL |=> settle_done;
  endproperty
  a_fast_wake: assert property (p_fast_wake) else $error("no immediate done");
  property p_xtal_wait;
    stop_release && !settle_busy && opt_clk_src == clk_ctrl_pkg::SRC_XTAL
      |=> settle_busy && !settle_done;
  endproperty
  a_xtal_wait: assert property (p_xtal_wait) else $error("crystal wait missing");
  property p_hold_osc; settle_busy && !osc_started |=> settle_busy; endproperty
  a_hold_osc: assert property (p_hold_osc) else $error("wait ended before osc");
  property p_min_wait; settle_busy && $rose(osc_started) |=> (!settle_done) [*8]; endproperty
  a_min_wait: assert property (p_min_wait) else $error("settle wait too short");
  property p_rd_zero; reg_rd |=> reg_rdata[7:2] == 6'h00; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unused bits not zero");
  property p_exp_step; $changed(cpu_div_exp) |-> cpu_clk_en || $past(cpu_clk_en);
  endproperty
  a_exp_step: assert property (p_exp_step) else $error("ratio change off boundary");
  c_done: cover property (settle_done);
  c_bad: cover property (div_setting_bad);
  c_stop: cover property (!slow_osc_run);
endmodule
bind clk_ctrl clk_ctrl_monitor i_mon (.mclk, .reset, .reg_rd, .reg_rdata, .opt_clk_src,
  .opt_slow_stoppable, .stop_release, .osc_started, .slow_osc_run, .watchdog_src_fixed,
  .cpu_clk_en, .periph_clk_en, .cpu_div_exp, .div_setting_bad, .settle_busy, .settle_done);

// ---- verification/tb_clk_ctrl.sv ----
// Purpose: Self-checking bench for the clock control block
// Assumes: Bench model keeps registers and ratios as integers
// Notes:   Settle test uses select 00 so the wait stays short
`timescale 1ns/1ps
module tb_clk_ctrl;
  logic        mclk = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_bit_wr = 0, reg_rd = 0;
  logic        opt_slow_stoppable = 1, stop_release = 0, osc_started = 0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wmask = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0]  opt_clk_src = 2'h0;
  logic        slow_osc_run, watchdog_src_fixed, cpu_clk_en, periph_clk_en;
  logic        div_setting_bad, settle_busy, settle_done;
  logic [2:0]  cpu_div_exp;
  int          mismatches = 0, checked = 0, n, mdl[int];
  int          pp[6] = '{0, 1, 0, 2, 1, 2};
  int          pc[6] = '{0, 0, 2, 0, 2, 2};
  clk_ctrl i_dut (.mclk, .reset, .clk_en, .reg_addr, .reg_wr, .reg_bit_wr, .reg_wmask,
    .reg_wdata, .reg_rd, .reg_rdata, .opt_clk_src, .opt_slow_stoppable, .stop_release,
    .osc_started, .slow_osc_run, .watchdog_src_fixed, .cpu_clk_en, .periph_clk_en,
    .cpu_div_exp, .div_setting_bad, .settle_busy, .settle_done);
  initial forever #20 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int msk(int a);
    case (a)
      16'hFF58: return 1;
      16'hFFFB: return 2;
      16'hFFF3, 16'hFFF4: return 3;
      default: return 0;
    endcase
  endfunction
  function automatic int cexp(int p, int c);
    case ({p[1:0], c[1]})
      3'b010: return 1;
      3'b001, 3'b100: return 2;
      3'b011: return 3;
      3'b101: return 4;
      default: return 0;
    endcase
  endfunction
  task automatic chk(string s, int e, logic [7:0] g);
    checked++;
    if (g !== 8'(e))
    begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", s, e, g);
    end
  endtask
  task automatic chk_n(string s, int e, int g);
    checked++;
    if (g != e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", s, e, g);
    end
  endtask
  task automatic cyc();
    @(posedge mclk);
    #1;
  endtask
  task automatic wr(int a, int d, int m, bit b);
    @(posedge mclk);
    reg_addr <= 16'(a);
    reg_wdata <= 8'(d);
    reg_wmask <= 8'(m);
    reg_bit_wr <= b;
    reg_wr <= 1;
    @(posedge mclk);
    reg_wr <= 0;
    if (b) d = (mdl[a] & ~m) | (d & m);
    mdl[a] = d & msk(a);
  endtask
  task automatic rd(int a);
    @(posedge mclk);
    reg_addr <= 16'(a);
    reg_rd <= 1;
    @(posedge mclk);
    reg_rd <= 0;
    #1;
    chk("rdata", mdl.exists(a) ? mdl[a] : 0, reg_rdata);
  endtask
  // Counts cycles between two ticks; bounded so a dead divider cannot hang
  task automatic gap(bit p, output int c);
    c = 0;
    repeat (40) if (!(p ? periph_clk_en : cpu_clk_en)) cyc();
    do
    begin
      cyc();
      c++;
    end
    while (!(p ? periph_clk_en : cpu_clk_en) && c < 40);
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(40 * 20000);
    mismatches++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'hD806));
    mdl[16'hFF58] = 0;
    mdl[16'hFFF3] = 2;
    mdl[16'hFFFB] = 2;
    repeat (20) @(posedge mclk);
    reset <= 0;
    rd(16'hFFFB);
    rd(16'hFFF3);
    rd(16'hFF58);
    rd(16'hFF00);
    gap(0, n);
    chk_n("cpu_period", 16, n);
    $display("reset test done");
    for (int i = 0; i < 6; i++)
    begin
      wr(16'hFFF3, ($urandom & 8'hFC) | pp[i], 8'hFF, 0);
      wr(16'hFFFB, ($urandom & 8'hFD) | pc[i], 8'h02, i[0]);
      rd(16'hFFF3);
      rd(16'hFFFB);
      repeat (40) cyc();
      gap(0, n);
      chk_n("cpu_period", 1 << cexp(pp[i], pc[i]), n);
      chk("cpu_exp", cexp(pp[i], pc[i]), cpu_div_exp);
      chk("bad", 0, div_setting_bad);
      gap(1, n);
      if (pp[i] != 0) chk_n("periph_period", 1 << pp[i], n);
    end
    wr(16'hFFF3, 3, 8'hFF, 0);
    cyc();
    chk("bad", 1, div_setting_bad);
    $display("divider test done");
    clk_en <= 1'b0;
    wr(16'hFF58, 1, 8'hFF, 0);
    mdl[16'hFF58] = 0;
    clk_en <= 1'b1;
    rd(16'hFF58);
    for (int s = 0; s < 2; s++)
      for (int b = 0; b < 2; b++)
      begin
        opt_slow_stoppable <= s[0];
        wr(16'hFF58, b, 8'h01, 1);
        cyc();
        chk("slow_run", !(s && b), slow_osc_run);
        chk("wd_fixed", !s, watchdog_src_fixed);
      end
    rd(16'hFF58);
    $display("slow osc test done");
    wr(16'hFFF4, $urandom & 8'hFC, 8'hFF, 0);
    rd(16'hFFF4);
    for (int s = 0; s < 3; s++)
    begin
      opt_clk_src <= 2'(s);
      @(posedge mclk);
      stop_release <= 1;
      @(posedge mclk);
      stop_release <= 0;
      #1;
      chk("busy", s == 1, settle_busy);
      chk("done", s != 1, settle_done);
      if (s == 1)
      begin
        repeat (20) cyc();
        chk("busy_hold", 1, settle_busy);
        @(posedge mclk);
        osc_started <= 1;
        n = 0;
        while (!settle_done && n < 1100)
        begin
          cyc();
          n++;
        end
        chk_n("settle_wait", 1, n >= 1023 && n <= 1027);
        osc_started <= 0;
      end
    end
    $display("settle test done");
    give_verdict();
  end
endmodule
